/* File: common/capture_buffer_pkg.sv */
// Constants, modes and states shared by the capture write buffering
package capture_buffer_pkg;

    localparam int unsigned NUM_BUFS       = 2;
    localparam int unsigned BUF_WORDS      = 16;
    localparam int unsigned WORD_W         = 32;
    localparam int unsigned XACT_PER_BUF   = 4;
    localparam int unsigned BEATS_PER_XACT = 4;
    localparam int unsigned MEM_IDX_W      = 5;
    localparam int unsigned ADDR_W         = 32;
    localparam int unsigned OFFSET_W       = 30;
    localparam int unsigned SAMPLE_W       = 10;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned HALF_W         = 16;
    localparam int unsigned EXT_W          = 6;
    localparam int unsigned SIGN_BIT       = 9;
    localparam int unsigned MODE_W         = 3;

    localparam logic [3:0] FIRST_WORD     = 4'h0;
    localparam logic [3:0] LAST_WORD      = 4'hF;
    localparam logic [1:0] LAST_BEAT      = 2'h3;
    localparam logic [1:0] LAST_XACT      = 2'h3;
    localparam logic [1:0] LAST_BYTE_LANE = 2'h3;
    localparam logic [1:0] LAST_HALF_LANE = 2'h1;
    // Half resolution keeps U0 Y0 V0 Y2 out of each eight-byte group
    localparam logic [7:0] HALFRES_KEEP   = 8'h27;

    typedef enum logic [2:0] {
        MODE_FULLRES  = 3'h0,
        MODE_HALFRES  = 3'h1,
        MODE_BYTE     = 3'h2,
        MODE_TEN_SIGN = 3'h3,
        MODE_TEN_UNS  = 3'h4,
        MODE_MESSAGE  = 3'h5
    } cap_mode_t;

    typedef enum logic [1:0] {
        DRAIN_IDLE = 2'h0,
        DRAIN_REQ  = 2'h1,
        DRAIN_BEAT = 2'h2
    } drain_state_t;

endpackage : capture_buffer_pkg

/* File: rtl/capture_packer.sv */
// Capture clock sample packer: decimation, extension and word packing
`timescale 1ns/100ps
module capture_packer (
    input  wire logic                         clk_cap_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         enable_i,
    input  wire capture_buffer_pkg::cap_mode_t mode_i,
    input  wire logic                         sample_valid_i,
    input  wire logic [9:0]                   sample_i,
    output logic                              word_valid_o,
    output logic [31:0]                       word_o
);

    logic [1:0]  lane;
    logic [2:0]  phase;
    logic [1:0]  next_lane;
    logic [2:0]  next_phase;
    logic [31:0] next_word;
    logic        next_word_valid;
    logic        keep;
    logic        ten_bit;
    logic [15:0] ext16;

    always_comb begin
        next_lane       = lane;
        next_phase      = phase;
        next_word       = word_o;
        next_word_valid = 1'b0;
        keep            = 1'b1;
        ten_bit = (mode_i == capture_buffer_pkg::MODE_TEN_SIGN) ||
                  (mode_i == capture_buffer_pkg::MODE_TEN_UNS);
        // 10-bit samples take a 16-bit slot, two bytes each
        if (mode_i == capture_buffer_pkg::MODE_TEN_SIGN) begin
            ext16 = {{capture_buffer_pkg::EXT_W{
                       sample_i[capture_buffer_pkg::SIGN_BIT]}}, sample_i};
        end else begin
            ext16 = {{capture_buffer_pkg::EXT_W{1'b0}}, sample_i};
        end
        if (!enable_i) begin
            next_lane  = 2'h0;
            next_phase = 3'h0;
        end else if (sample_valid_i) begin
            // Decimate Y, U and V by two ahead of the buffers
            if (mode_i == capture_buffer_pkg::MODE_HALFRES) begin
                keep       = capture_buffer_pkg::HALFRES_KEEP[phase];
                next_phase = phase + 3'h1;
            end
            if (keep && ten_bit) begin
                next_word[lane[0]*capture_buffer_pkg::HALF_W +:
                          capture_buffer_pkg::HALF_W] = ext16;
                if (lane == capture_buffer_pkg::LAST_HALF_LANE) begin
                    next_word_valid = 1'b1;
                    next_lane       = 2'h0;
                end else begin
                    next_lane = lane + 2'h1;
                end
            end else if (keep) begin
                // Four bytes to a word, one per kept valid sample
                next_word[lane*capture_buffer_pkg::BYTE_W +:
                          capture_buffer_pkg::BYTE_W] = sample_i[7:0];
                next_word_valid = (lane == capture_buffer_pkg::LAST_BYTE_LANE);
                next_lane       = lane + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_cap_i) begin
        if (!rst_n_i) begin
            lane         <= 2'h0;
            phase        <= 3'h0;
            word_o       <= 32'h0000_0000;
            word_valid_o <= 1'b0;
        end else begin
            lane         <= next_lane;
            phase        <= next_phase;
            word_o       <= next_word;
            word_valid_o <= next_word_valid;
        end
    end

endmodule : capture_packer

/* File: rtl/video_capture_write_buffering.sv */
// Ping-pong write buffering of the video capture unit toward the highway
//
// What this block does
// - Two internal buffers stage data, each sixteen 32-bit words.
// - Full resolution fills a buffer with 32 Y, 16 U, 16 V samples.
// - A full buffer drains in four highway writes while the other fills.
// - Half resolution decimates Y, U and V by two before buffering.
// - Byte and message modes hold 64 samples per buffer.
// - Ten-bit modes hold 32 samples per buffer in 16-bit slots.
// - Each ten-bit sample costs two bytes of bandwidth and storage.
// - Full resolution line traffic follows ceil(2W/64) times four transfers.
// - Half resolution line traffic follows ceil(2W/128) times four transfers.
// - Byte and message bandwidth depends only on capture clock rate.
// - Loopback select takes input from video output data, not pins.
// - Both buffers full raises error, drops samples, resumes at right address.
// - Bandwidth error stays set until software acknowledges with a one.
// - Byte capture packs four consecutive samples into each word.
`timescale 1ns/100ps
module video_capture_write_buffering (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_cap_i,
    input  wire logic [9:0]  cap_data_i,
    input  wire logic        cap_valid_i,
    input  wire logic [7:0]  vo_data_i,
    input  wire logic        vo_valid_i,
    input  wire logic        loopback_select_i,
    input  wire logic        capture_enable_i,
    input  wire logic [2:0]  capture_mode_i,
    input  wire logic [31:0] base_address_i,
    input  wire logic        error_ack_i,
    input  wire logic        hw_gnt_i,
    output logic             hw_req_o,
    output logic [31:0]      hw_addr_o,
    output logic [31:0]      hw_wdata_o,
    output logic             hw_wvalid_o,
    output logic             bandwidth_overflow_error_o,
    output logic [1:0]       buffers_pending_o
);

    // Storage shared by both domains, written on the capture clock only
    logic [31:0] buf_mem [capture_buffer_pkg::NUM_BUFS *
                          capture_buffer_pkg::BUF_WORDS];
    logic [29:0] buf_start [capture_buffer_pkg::NUM_BUFS];

    // Capture clock domain reset
    logic cap_rst_meta;
    logic cap_rst_n;

    always_ff @(posedge clk_cap_i) begin
        cap_rst_meta <= rst_n_i;
        cap_rst_n    <= cap_rst_meta;
    end

    // Pin and control synchronisers on the capture clock
    logic [9:0] pin_data_meta;
    logic [9:0] pin_data_sync;
    logic       pin_valid_meta;
    logic       pin_valid_sync;
    logic [7:0] vo_data_meta;
    logic [7:0] vo_data_sync;
    logic       vo_valid_meta;
    logic       vo_valid_sync;
    logic       loop_meta;
    logic       loop_sync;
    logic       en_meta;
    logic       en_sync;
    logic [2:0] mode_meta;
    logic [2:0] mode_sync;
    logic [1:0] drain_meta;
    logic [1:0] drain_sync;

    logic [1:0] drain_tgl;

    always_ff @(posedge clk_cap_i) begin
        if (!cap_rst_n) begin
            pin_data_meta  <= 10'h000;
            pin_data_sync  <= 10'h000;
            pin_valid_meta <= 1'b0;
            pin_valid_sync <= 1'b0;
            vo_data_meta   <= 8'h00;
            vo_data_sync   <= 8'h00;
            vo_valid_meta  <= 1'b0;
            vo_valid_sync  <= 1'b0;
            loop_meta      <= 1'b0;
            loop_sync      <= 1'b0;
            en_meta        <= 1'b0;
            en_sync        <= 1'b0;
            mode_meta      <= 3'h0;
            mode_sync      <= 3'h0;
            drain_meta     <= 2'h0;
            drain_sync     <= 2'h0;
        end else begin
            pin_data_meta  <= cap_data_i;
            pin_data_sync  <= pin_data_meta;
            pin_valid_meta <= cap_valid_i;
            pin_valid_sync <= pin_valid_meta;
            vo_data_meta   <= vo_data_i;
            vo_data_sync   <= vo_data_meta;
            vo_valid_meta  <= vo_valid_i;
            vo_valid_sync  <= vo_valid_meta;
            loop_meta      <= loopback_select_i;
            loop_sync      <= loop_meta;
            en_meta        <= capture_enable_i;
            en_sync        <= en_meta;
            mode_meta      <= capture_mode_i;
            mode_sync      <= mode_meta;
            drain_meta     <= drain_tgl;
            drain_sync     <= drain_meta;
        end
    end

    // Input source selection
    logic       src_valid;
    logic [9:0] src_data;

    always_comb begin
        if (loop_sync) begin
            src_valid = vo_valid_sync;
            src_data  = {2'h0, vo_data_sync};
        end else begin
            src_valid = pin_valid_sync;
            src_data  = pin_data_sync;
        end
    end

    logic        word_valid;
    logic [31:0] word;

    capture_packer u_packer (
        .clk_cap_i      (clk_cap_i),
        .rst_n_i        (cap_rst_n),
        .enable_i       (en_sync),
        .mode_i         (capture_buffer_pkg::cap_mode_t'(mode_sync)),
        .sample_valid_i (src_valid),
        .sample_i       (src_data),
        .word_valid_o   (word_valid),
        .word_o         (word)
    );

    // Buffer filling on the capture clock
    logic        wr_buf;
    logic [3:0]  wr_idx;
    logic        filling;
    logic        dropping;
    logic [29:0] word_offset;
    logic [1:0]  fill_tgl;
    logic        drop_tgl;
    logic        next_wr_buf;
    logic [3:0]  next_wr_idx;
    logic        next_filling;
    logic        next_dropping;
    logic [29:0] next_word_offset;
    logic [1:0]  next_fill_tgl;
    logic        next_drop_tgl;
    logic [1:0]  cap_busy;
    logic        mem_we;

    always_comb begin
        next_wr_buf      = wr_buf;
        next_wr_idx      = wr_idx;
        next_filling     = filling;
        next_dropping    = dropping;
        next_word_offset = word_offset;
        next_fill_tgl    = fill_tgl;
        next_drop_tgl    = drop_tgl;
        mem_we           = 1'b0;
        cap_busy         = fill_tgl ^ drain_sync;
        if (!en_sync) begin
            next_wr_idx      = capture_buffer_pkg::FIRST_WORD;
            next_filling     = 1'b0;
            next_dropping    = 1'b0;
            next_word_offset = 30'h0000_0000;
        end else if (word_valid) begin
            next_word_offset = word_offset + 30'h0000_0001;
            if (filling || !cap_busy[wr_buf]) begin
                mem_we        = 1'b1;
                next_filling  = 1'b1;
                next_dropping = 1'b0;
                next_wr_idx   = wr_idx + 4'h1;
                if (wr_idx == capture_buffer_pkg::LAST_WORD) begin
                    next_fill_tgl[wr_buf] = ~fill_tgl[wr_buf];
                    next_wr_buf  = ~wr_buf;
                    next_filling = 1'b0;
                end
            end else begin
                // Both buffers held: word lost, one event per episode
                next_dropping = 1'b1;
                if (!dropping) begin
                    next_drop_tgl = ~drop_tgl;
                end
            end
        end
    end

    always_ff @(posedge clk_cap_i) begin
        if (!cap_rst_n) begin
            wr_buf      <= 1'b0;
            wr_idx      <= capture_buffer_pkg::FIRST_WORD;
            filling     <= 1'b0;
            dropping    <= 1'b0;
            word_offset <= 30'h0000_0000;
            fill_tgl    <= 2'h0;
            drop_tgl    <= 1'b0;
        end else begin
            wr_buf      <= next_wr_buf;
            wr_idx      <= next_wr_idx;
            filling     <= next_filling;
            dropping    <= next_dropping;
            word_offset <= next_word_offset;
            fill_tgl    <= next_fill_tgl;
            drop_tgl    <= next_drop_tgl;
        end
    end

    // Buffer storage and start offset, stable while the buffer is pending
    always_ff @(posedge clk_cap_i) begin
        if (mem_we) begin
            buf_mem[{wr_buf, wr_idx}] <= word;
            if (wr_idx == capture_buffer_pkg::FIRST_WORD) begin
                buf_start[wr_buf] <= word_offset;
            end
        end
    end

    // Capture events into the system clock
    logic [1:0] fill_meta;
    logic [1:0] fill_sync;
    logic       drop_meta;
    logic       drop_sync;
    logic       drop_seen;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fill_meta <= 2'h0;
            fill_sync <= 2'h0;
            drop_meta <= 1'b0;
            drop_sync <= 1'b0;
            drop_seen <= 1'b0;
        end else begin
            fill_meta <= fill_tgl;
            fill_sync <= fill_meta;
            drop_meta <= drop_tgl;
            drop_sync <= drop_meta;
            drop_seen <= drop_sync;
        end
    end

    // Highway drain on the system clock
    capture_buffer_pkg::drain_state_t state;
    capture_buffer_pkg::drain_state_t next_state;
    logic        rd_buf;
    logic [1:0]  xact;
    logic [1:0]  beat;
    logic        next_rd_buf;
    logic [1:0]  next_xact;
    logic [1:0]  next_beat;
    logic [1:0]  next_drain_tgl;
    logic        next_req;
    logic [31:0] next_addr;
    logic [31:0] next_wdata;
    logic        next_wvalid;
    logic        next_error;
    logic [1:0]  pending;
    logic [29:0] xact_offset;

    always_comb begin
        next_state     = state;
        next_rd_buf    = rd_buf;
        next_xact      = xact;
        next_beat      = beat;
        next_drain_tgl = drain_tgl;
        next_req       = hw_req_o;
        next_addr      = hw_addr_o;
        next_wdata     = hw_wdata_o;
        next_wvalid    = 1'b0;
        pending        = fill_sync ^ drain_tgl;
        xact_offset    = buf_start[rd_buf] + {26'h000_0000, xact, 2'h0};
        // Set wins over acknowledge
        next_error = (bandwidth_overflow_error_o & ~error_ack_i) |
                     (drop_sync ^ drop_seen);
        case (state)
            capture_buffer_pkg::DRAIN_IDLE: begin
                if (pending[rd_buf]) begin
                    next_req   = 1'b1;
                    next_xact  = 2'h0;
                    next_addr  = base_address_i +
                                 {buf_start[rd_buf], 2'h0};
                    next_state = capture_buffer_pkg::DRAIN_REQ;
                end
            end
            capture_buffer_pkg::DRAIN_REQ: begin
                // Address steps only after the last beat is out
                next_addr = base_address_i + {xact_offset, 2'h0};
                if (hw_gnt_i) begin
                    next_beat  = 2'h0;
                    next_state = capture_buffer_pkg::DRAIN_BEAT;
                end
            end
            capture_buffer_pkg::DRAIN_BEAT: begin
                next_wvalid = 1'b1;
                next_wdata  = buf_mem[{rd_buf, xact, beat}];
                next_beat   = beat + 2'h1;
                if (beat == capture_buffer_pkg::LAST_BEAT) begin
                    if (xact == capture_buffer_pkg::LAST_XACT) begin
                        // Four writes done: release and swap
                        next_req               = 1'b0;
                        next_drain_tgl[rd_buf] = ~drain_tgl[rd_buf];
                        next_rd_buf            = ~rd_buf;
                        next_state = capture_buffer_pkg::DRAIN_IDLE;
                    end else begin
                        next_xact  = xact + 2'h1;
                        next_state = capture_buffer_pkg::DRAIN_REQ;
                    end
                end
            end
            default: begin
                next_state = capture_buffer_pkg::DRAIN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state                      <= capture_buffer_pkg::DRAIN_IDLE;
            rd_buf                     <= 1'b0;
            xact                       <= 2'h0;
            beat                       <= 2'h0;
            drain_tgl                  <= 2'h0;
            hw_req_o                   <= 1'b0;
            hw_addr_o                  <= 32'h0000_0000;
            hw_wdata_o                 <= 32'h0000_0000;
            hw_wvalid_o                <= 1'b0;
            bandwidth_overflow_error_o <= 1'b0;
            buffers_pending_o          <= 2'h0;
        end else begin
            state                      <= next_state;
            rd_buf                     <= next_rd_buf;
            xact                       <= next_xact;
            beat                       <= next_beat;
            drain_tgl                  <= next_drain_tgl;
            hw_req_o                   <= next_req;
            hw_addr_o                  <= next_addr;
            hw_wdata_o                 <= next_wdata;
            hw_wvalid_o                <= next_wvalid;
            bandwidth_overflow_error_o <= next_error;
            buffers_pending_o          <= pending;
        end
    end

endmodule : video_capture_write_buffering

/* File: test/capture_buffer_properties.sv */
// Concurrent checks on the capture write buffering ports
`timescale 1ns/100ps
module capture_buffer_properties (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        clk_cap_i,
    input wire logic        error_ack_i,
    input wire logic        hw_gnt_i,
    input wire logic        hw_req_o,
    input wire logic [31:0] hw_addr_o,
    input wire logic        hw_wvalid_o,
    input wire logic        bandwidth_overflow_error_o,
    input wire logic [1:0]  buffers_pending_o
);
    logic [1:0] prev_pend, next_prev_pend;
    logic [4:0] beat_cnt, next_beat_cnt;
    logic [3:0] since_full, next_since_full;
    logic       drained;

    always_comb begin
        drained         = |(prev_pend & ~buffers_pending_o);
        next_prev_pend  = buffers_pending_o;
        next_beat_cnt   = drained ? 5'h00 : beat_cnt + {4'h0, hw_wvalid_o};
        next_since_full = (buffers_pending_o == 2'h3) ? 4'h0 :
                          (since_full == 4'hF) ? 4'hF : since_full + 4'h1;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            prev_pend  <= 2'h0;
            beat_cnt   <= 5'h00;
            since_full <= 4'hF;
        end else begin
            prev_pend  <= next_prev_pend;
            beat_cnt   <= next_beat_cnt;
            since_full <= next_since_full;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence taken_grant;
        hw_gnt_i && hw_req_o && !hw_wvalid_o;
    endsequence
    sequence four_beats;
        hw_wvalid_o [*4] ##1 !hw_wvalid_o;
    endsequence

    a_grant_starts_beats: assert property (taken_grant |-> ##2 four_beats)
        else $error("beats did not follow grant");
    a_burst_four_beats: assert property ($rose(hw_wvalid_o) |-> four_beats)
        else $error("transaction not four beats");
    a_addr_next_xact: assert property ($fell(hw_wvalid_o) && hw_req_o |->
        hw_addr_o == $past(hw_addr_o) + 32'h00000010)
        else $error("address did not step by 16");
    a_addr_held: assert property (hw_wvalid_o |-> $stable(hw_addr_o))
        else $error("address moved during beats");
    a_req_follows_pend: assert property (buffers_pending_o != 2'h0 &&
        !hw_req_o && !$past(hw_req_o) |-> ##[1:4] hw_req_o)
        else $error("pending buffer without request");
    a_req_needs_pend: assert property ($rose(hw_req_o) |->
        buffers_pending_o != 2'h0)
        else $error("request without pending buffer");
    a_drain_sixteen: assert property (drained |-> beat_cnt == 5'h10)
        else $error("buffer freed without sixteen words");
    a_error_sticky: assert property (bandwidth_overflow_error_o &&
        !error_ack_i |=> bandwidth_overflow_error_o)
        else $error("error flag dropped without ack");
    a_error_ack: assert property ($fell(bandwidth_overflow_error_o) |->
        $past(error_ack_i))
        else $error("error flag cleared without ack");
    a_error_cause: assert property ($rose(bandwidth_overflow_error_o) |->
        since_full <= 4'h8)
        else $error("error raised while a buffer was free");
endmodule : capture_buffer_properties

bind video_capture_write_buffering capture_buffer_properties chk_u (
    .clk_sys_i, .rst_n_i, .clk_cap_i, .error_ack_i, .hw_gnt_i, .hw_req_o,
    .hw_addr_o, .hw_wvalid_o, .bandwidth_overflow_error_o, .buffers_pending_o
);

/* File: test/highway_arbiter_model.sv */
// Highway arbiter model granting capture write transactions
`timescale 1ns/100ps
module highway_arbiter_model (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        hw_req_i,
    input  wire logic        hw_wvalid_i,
    input  wire logic [15:0] delay_i,
    output logic             hw_gnt_o
);
    logic [15:0] wait_cnt;
    logic [2:0]  beats_left;

    always @(posedge clk_sys_i) begin
        hw_gnt_o <= 1'b0;
        if (!rst_n_i) begin
            wait_cnt   <= 16'h0000;
            beats_left <= 3'h0;
        end else if (beats_left != 3'h0) begin
            // No grant while a transaction is still moving
            if (hw_wvalid_i) begin
                beats_left <= beats_left - 3'h1;
            end
        end else if (hw_req_i) begin
            if (wait_cnt >= delay_i) begin
                hw_gnt_o   <= 1'b1;
                beats_left <= 3'h4;
                wait_cnt   <= 16'h0000;
            end else begin
                wait_cnt <= wait_cnt + 16'h0001;
            end
        end
    end
endmodule : highway_arbiter_model

/* File: test/video_capture_write_buffering_test.sv */
// Self-checking bench of the capture write buffering
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module video_capture_write_buffering_test;
    typedef logic [31:0] words_t [$];
    logic clk_sys_i = 0, clk_cap_i = 0, rst_n_i = 0, cap_valid_i = 0;
    logic vo_valid_i = 0, loopback_select_i = 0, capture_enable_i = 0;
    logic error_ack_i = 0, hw_gnt_i, hw_req_o, hw_wvalid_o, err;
    logic [9:0]  cap_data_i = 10'h000, smp [$];
    logic [7:0]  vo_data_i = 8'h00;
    logic [2:0]  capture_mode_i = 3'h0;
    logic [31:0] base_address_i = 32'h00001000, hw_addr_o, hw_wdata_o;
    logic [31:0] got [int];
    logic [1:0]  buffers_pending_o;
    logic [15:0] gnt_delay = 16'h0000;
    logic [2:0]  mode_tab [7] = '{3'h2, 3'h3, 3'h4, 3'h0, 3'h1, 3'h5, 3'h2};
    int n_tab [7] = '{128, 64, 64, 128, 256, 128, 128};
    int failures = 0, n_compared = 0, n_xact = 0, beat_idx = 0;

    video_capture_write_buffering dut_u (
        .clk_sys_i, .rst_n_i, .clk_cap_i, .cap_data_i, .cap_valid_i,
        .vo_data_i, .vo_valid_i, .loopback_select_i, .capture_enable_i,
        .capture_mode_i, .base_address_i, .error_ack_i, .hw_gnt_i,
        .hw_req_o, .hw_addr_o, .hw_wdata_o, .hw_wvalid_o,
        .bandwidth_overflow_error_o(err), .buffers_pending_o);
    highway_arbiter_model arb_u (.clk_sys_i, .rst_n_i, .hw_req_i(hw_req_o),
        .hw_wvalid_i(hw_wvalid_o), .delay_i(gnt_delay), .hw_gnt_o(hw_gnt_i));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #4;
        forever #7.5 clk_cap_i = ~clk_cap_i;
    end

    // Collects written words by word offset from the base
    always @(posedge clk_sys_i) begin
        if (hw_wvalid_o) begin
            if (beat_idx == 0) n_xact++;
            got[int'((hw_addr_o - base_address_i) >> 2) + beat_idx] = hw_wdata_o;
            beat_idx = (beat_idx + 1) % 4;
        end else begin
            beat_idx = 0;
        end
    end

    function automatic logic [15:0] ext(logic [2:0] m, logic [9:0] x);
        return (m == 3'h3) ? {{6{x[9]}}, x} : {6'h00, x};
    endfunction : ext

    function automatic words_t expect_words(logic [2:0] m, logic [9:0] s [$]);
        words_t w;
        logic [7:0] b [$];
        if (m == 3'h3 || m == 3'h4) begin
            for (int i = 0; i + 1 < s.size(); i += 2)
                w.push_back({ext(m, s[i + 1]), ext(m, s[i])});
            return w;
        end
        foreach (s[i])
            if (m != 3'h1 || capture_buffer_pkg::HALFRES_KEEP[i % 8])
                b.push_back(s[i][7:0]);
        for (int i = 0; i + 3 < b.size(); i += 4)
            w.push_back({b[i + 3], b[i + 2], b[i + 1], b[i]});
        return w;
    endfunction : expect_words

    task automatic send(int n, logic [2:0] m, logic lb);
        int k;
        k = 0;
        smp = {};
        @(negedge clk_sys_i);
        capture_enable_i = 1'b0;
        capture_mode_i = m;
        loopback_select_i = lb;
        base_address_i = {20'h00001, 6'($urandom), 6'h00};
        repeat (10) @(negedge clk_cap_i);
        capture_enable_i = 1'b1;
        repeat (8) @(negedge clk_cap_i);
        while (k < n) begin
            @(negedge clk_cap_i);
            cap_valid_i = ($urandom % 4) != 0;
            vo_valid_i = cap_valid_i;
            cap_data_i = 10'($urandom);
            vo_data_i = 8'($urandom);
            if (cap_valid_i) begin
                smp.push_back(lb ? {2'h0, vo_data_i} : cap_data_i);
                k++;
            end
        end
        @(negedge clk_cap_i);
        cap_valid_i = 1'b0;
        vo_valid_i = 1'b0;
    endtask : send

    task automatic wait_idle();
        int t;
        t = 0;
        repeat (20) @(negedge clk_sys_i);
        while ((hw_req_o !== 1'b0 || buffers_pending_o !== 2'h0) && t < 3000) begin
            @(negedge clk_sys_i);
            t++;
        end
        `CHK("drained", 1'b1, t < 3000)
    endtask : wait_idle

    task automatic run(logic [2:0] m, int n, logic lb);
        words_t e;
        got.delete();
        n_xact = 0;
        send(n, m, lb);
        wait_idle();
        e = expect_words(m, smp);
        if (gnt_delay < 16'h0010) begin
            `CHK("xacts", 8, n_xact)
            foreach (e[i]) `CHK("word", e[i], got[i])
        end else begin
            `CHK("ovf_flag", 1'b1, err)
            `CHK("dropped", 1'b1, got.num() < e.size())
            foreach (e[i]) if (got.exists(i)) `CHK("resume", e[i], got[i])
        end
    endtask : run

    task automatic print_verdict();
        $display("counts: %0d compared, %0d failures", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        #400000;
        failures++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hBEFF));
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        for (int t = 0; t < 7; t++) begin
            gnt_delay = 16'($urandom % 4);
            run(mode_tab[t], n_tab[t], t == 6);
            $display("test %0d done", t);
        end
        gnt_delay = 16'h003C;
        run(3'h2, 384, 1'b0);
        repeat (5) @(negedge clk_sys_i);
        `CHK("err_held", 1'b1, err)
        error_ack_i = 1'b1;
        @(negedge clk_sys_i);
        error_ack_i = 1'b0;
        @(negedge clk_sys_i);
        `CHK("err_clear", 1'b0, err)
        $display("test overflow done");
        print_verdict();
    end
endmodule : video_capture_write_buffering_test
